// >>> design/tcc_pkg.sv
package tcc_pkg;
	// channel count and data widths
	localparam int          NCH        = 7;
	localparam int          AW         = 8;
	localparam int          DW         = 32;
	localparam int          RW         = 16;

	// register indices; byte address is four times the index
	localparam logic [5:0]  IDX_CTL0   = 6'h02;
	localparam logic [5:0]  IDX_COUNT  = 6'h10;
	localparam logic [5:0]  IDX_CCR0   = 6'h12;
	localparam logic [5:0]  IDX_VEC    = 6'h2E;
	localparam logic [5:0]  IDX_STAT   = 6'h30;
	localparam logic [5:0]  IDX_MASK   = 6'h32;
	localparam logic [5:0]  IDX_STEP   = 6'h02;
	localparam logic [5:0]  IDX_SPAN   = 6'h0C;

	// channel control field positions
	localparam int          F_EDGE_LO  = 14;
	localparam int          F_SRC_LO   = 12;
	localparam int          F_SYNC     = 11;
	localparam int          F_LATCH    = 10;
	localparam int          F_FUNC     = 8;
	localparam int          F_MODE_LO  = 5;
	localparam int          F_IE       = 4;
	localparam int          F_LIVE     = 3;
	localparam int          F_OUT      = 2;
	localparam int          F_COV      = 1;
	localparam int          F_FLAG     = 0;
	localparam logic [15:0] CTL_WMASK  = 16'hF9F7;
	localparam logic [15:0] CTL_RESET  = 16'h0000;
	localparam logic [15:0] CCR_RESET  = 16'h0000;

	// edge selector codes
	localparam logic [1:0]  EDGE_RISE  = 2'h1;
	localparam logic [1:0]  EDGE_FALL  = 2'h2;
	localparam logic [1:0]  EDGE_BOTH  = 2'h3;

	// input source codes
	localparam logic [1:0]  SRC_FIRST  = 2'h0;
	localparam logic [1:0]  SRC_SECOND = 2'h1;
	localparam logic [1:0]  SRC_LOW    = 2'h2;
	localparam logic [1:0]  SRC_HIGH   = 2'h3;

	// waveform modes
	localparam logic [2:0]  MODE_LEVEL = 3'h0;
	localparam logic [2:0]  MODE_SET   = 3'h1;
	localparam logic [2:0]  MODE_TGRST = 3'h2;
	localparam logic [2:0]  MODE_SETRST = 3'h3;
	localparam logic [2:0]  MODE_TGL   = 3'h4;
	localparam logic [2:0]  MODE_RST   = 3'h5;
	localparam logic [2:0]  MODE_TGSET = 3'h6;
	localparam logic [2:0]  MODE_RSTSET = 3'h7;

	// vector values and own status layout
	localparam logic [15:0] VEC_NONE   = 16'h0000;
	localparam logic [15:0] VEC_ROLL   = 16'h000E;
	localparam int          STAT_ROLL  = 7;
	localparam logic [7:0]  STAT_RESET = 8'h00;

	// bus responses
	localparam logic [1:0]  RESP_OKAY  = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;
endpackage

// >>> design/timer_capture_compare_channels.sv
`timescale 1ns/1ps
`default_nettype none

module timer_capture_compare_channels (
	input  wire logic                  sys_clk_in,                  // timer clock
	input  wire logic                  sys_rst_in,                  // synchronous reset, high
	input  wire logic                  ce_in,                       // clock enable, freezes state when low
	input  wire logic [tcc_pkg::AW-1:0] s_axi_awaddr_in,            // write address
	input  wire logic                  s_axi_awvalid_in,            // write address valid
	output logic                       s_axi_awready_out,           // write address ready
	input  wire logic [tcc_pkg::DW-1:0] s_axi_wdata_in,             // write data
	input  wire logic [3:0]            s_axi_wstrb_in,              // write byte strobes
	input  wire logic                  s_axi_wvalid_in,             // write data valid
	output logic                       s_axi_wready_out,            // write data ready
	output logic [1:0]                 s_axi_bresp_out,             // write response
	output logic                       s_axi_bvalid_out,            // write response valid
	input  wire logic                  s_axi_bready_in,             // write response ready
	input  wire logic [tcc_pkg::AW-1:0] s_axi_araddr_in,            // read address
	input  wire logic                  s_axi_arvalid_in,            // read address valid
	output logic                       s_axi_arready_out,           // read address ready
	output logic [tcc_pkg::DW-1:0]     s_axi_rdata_out,             // read data
	output logic [1:0]                 s_axi_rresp_out,             // read response
	output logic                       s_axi_rvalid_out,            // read data valid
	input  wire logic                  s_axi_rready_in,             // read data ready
	input  wire logic [tcc_pkg::NCH-1:0] first_external_input_in,   // first capture input per channel
	input  wire logic [tcc_pkg::NCH-1:0] second_external_input_in,  // second capture input per channel
	input  wire logic [tcc_pkg::RW-1:0] running_count_in,           // counter value, same clock
	input  wire logic                  rollover_event_in,           // counter wrap pulse, same clock
	output logic [tcc_pkg::NCH-1:0]    waveform_out,                // compare outputs, registered
	output logic                       irq_out                      // level interrupt
);

	// the whole block state in one record, registered by a single always_ff
	typedef struct packed {
		logic [tcc_pkg::NCH-1:0][15:0] ctl;
		logic [tcc_pkg::NCH-1:0][15:0] ccr;
		logic [tcc_pkg::NCH-1:0]       a_s1;
		logic [tcc_pkg::NCH-1:0]       a_s2;
		logic [tcc_pkg::NCH-1:0]       b_s1;
		logic [tcc_pkg::NCH-1:0]       b_s2;
		logic [tcc_pkg::NCH-1:0]       sel_q;
		logic [tcc_pkg::NCH-1:0]       prev;
		logic [tcc_pkg::NCH-1:0]       eq;
		logic [tcc_pkg::NCH-1:0]       wave;
		logic                          roll_flag;
		logic [7:0]                    mask;
		logic                          have_aw;
		logic                          have_w;
		logic [5:0]                    aw_idx;
		logic                          aw_hi;
		logic [15:0]                   wdata;
		logic [1:0]                    wstrb;
		logic                          bvalid;
		logic [1:0]                    bresp;
		logic                          rvalid;
		logic [1:0]                    rresp;
		logic [tcc_pkg::DW-1:0]        rdata;
	} state_t;

	state_t state_q;
	state_t state_d;

	// combinational views of the registered state
	logic [tcc_pkg::NCH-1:0] sel_live;
	logic [tcc_pkg::NCH-1:0] cap_in;
	logic [tcc_pkg::NCH-1:0] match_ev;
	logic [tcc_pkg::NCH-1:0] cap_ev;
	logic [tcc_pkg::NCH-1:0] chan_req;
	logic [7:0]              stat_view;
	logic [15:0]             vec_val;
	logic [2:0]              vec_ch;
	logic                    vec_any;

	// map an index onto a channel slot of a register group
	function automatic logic [3:0] slot(input logic [5:0] idx, input logic [5:0] base);
		logic [5:0] off;
		// channels sit on every second index, so odd offsets fall outside
		off = idx - base;
		if (idx >= base && off <= tcc_pkg::IDX_SPAN && !off[0]) begin
			slot = {1'b0, off[3:1]};
		end else begin
			slot = 4'hF;
		end
	endfunction

	// read view of one register index
	function automatic logic [16:0] read_reg(input state_t s, input logic [5:0] idx,
	                                         input logic [tcc_pkg::NCH-1:0] live,
	                                         input logic [7:0] stat, input logic [15:0] vec,
	                                         input logic [15:0] count);
		logic [3:0]  c;
		logic [3:0]  r;
		logic [15:0] v;
		c = slot(idx, tcc_pkg::IDX_CTL0);
		r = slot(idx, tcc_pkg::IDX_CCR0);
		v = 16'h0000;
		read_reg = 17'h0_0000;
		if (c != 4'hF) begin
			v = s.ctl[c[2:0]];
			v[9] = 1'b0;
			v[tcc_pkg::F_LIVE] = live[c[2:0]];
			read_reg = {1'b1, v};
		end else if (r != 4'hF) begin
			read_reg = {1'b1, s.ccr[r[2:0]]};
		end else if (idx == tcc_pkg::IDX_COUNT) begin
			read_reg = {1'b1, count};
		end else if (idx == tcc_pkg::IDX_VEC) begin
			read_reg = {1'b1, vec};
		end else if (idx == tcc_pkg::IDX_STAT) begin
			// own status and mask sit in the low byte, the upper byte reads zero
			read_reg = {1'b1, 8'h00, stat};
		end else if (idx == tcc_pkg::IDX_MASK) begin
			read_reg = {1'b1, 8'h00, s.mask};
		end
	endfunction

	// selected input, capture path, events and vector priority
	always_comb begin
		for (int i = 0; i < tcc_pkg::NCH; i++) begin
			unique case (state_q.ctl[i][tcc_pkg::F_SRC_LO +: 2])
				tcc_pkg::SRC_FIRST:  sel_live[i] = state_q.a_s2[i];
				tcc_pkg::SRC_SECOND: sel_live[i] = state_q.b_s2[i];
				tcc_pkg::SRC_LOW:    sel_live[i] = 1'b0;
				tcc_pkg::SRC_HIGH:   sel_live[i] = 1'b1;
			endcase
			cap_in[i] = state_q.ctl[i][tcc_pkg::F_SYNC] ? state_q.sel_q[i] : sel_live[i];
			unique case (state_q.ctl[i][tcc_pkg::F_EDGE_LO +: 2])
				tcc_pkg::EDGE_RISE: cap_ev[i] = cap_in[i] & ~state_q.prev[i];
				tcc_pkg::EDGE_FALL: cap_ev[i] = ~cap_in[i] & state_q.prev[i];
				tcc_pkg::EDGE_BOTH: cap_ev[i] = cap_in[i] ^ state_q.prev[i];
				default:            cap_ev[i] = 1'b0;
			endcase
			cap_ev[i] = cap_ev[i] & state_q.ctl[i][tcc_pkg::F_FUNC];
			// match fires once when the count becomes equal to the value
			match_ev[i] = !state_q.ctl[i][tcc_pkg::F_FUNC] && running_count_in == state_q.ccr[i]
			              && !state_q.eq[i];
			chan_req[i] = state_q.ctl[i][tcc_pkg::F_IE] & state_q.ctl[i][tcc_pkg::F_FLAG];
			stat_view[i] = state_q.ctl[i][tcc_pkg::F_FLAG];
		end
		stat_view[tcc_pkg::STAT_ROLL] = state_q.roll_flag;
		vec_any = 1'b0;
		vec_ch = 3'h0;
		vec_val = tcc_pkg::VEC_NONE;
		// scan channels 6 down to 1 so the lowest pending one, the highest priority, is kept; channel 0 is never reported
		for (int i = tcc_pkg::NCH - 1; i >= 1; i--) begin
			if (state_q.ctl[i][tcc_pkg::F_FLAG]) begin
				vec_any = 1'b1;
				vec_ch = 3'(i);
			end
		end
		if (vec_any) begin
			vec_val = {12'h000, vec_ch, 1'b0};
		end else if (state_q.roll_flag) begin
			vec_val = tcc_pkg::VEC_ROLL;
		end
	end

	// next state: bus, register writes, clears, then hardware sets so that sets win
	always_comb begin
		logic [3:0]  wc;
		logic [3:0]  wr;
		logic [15:0] bm;
		logic [16:0] rd;
		logic        do_w;
		logic        do_r;
		logic [2:0]  md;
		logic        w;
		state_d = state_q;
		wc = 4'hF;
		wr = 4'hF;
		bm = {{8{state_q.wstrb[1]}}, {8{state_q.wstrb[0]}}};
		rd = 17'h0_0000;
		do_w = 1'b0;
		do_r = 1'b0;
		md = 3'h0;
		w = 1'b0;

		// write address and data are taken in either order
		if (s_axi_awvalid_in && s_axi_awready_out) begin
			state_d.have_aw = 1'b1;
			state_d.aw_idx = s_axi_awaddr_in[7:2];
			state_d.aw_hi = |s_axi_awaddr_in[1:0];
		end
		if (s_axi_wvalid_in && s_axi_wready_out) begin
			state_d.have_w = 1'b1;
			state_d.wdata = s_axi_wdata_in[15:0];
			state_d.wstrb = s_axi_wstrb_in[1:0];
		end
		if (state_q.have_aw && state_q.have_w && !state_q.bvalid) begin
			do_w = 1'b1;
			state_d.have_aw = 1'b0;
			state_d.have_w = 1'b0;
			state_d.bvalid = 1'b1;
			rd = read_reg(state_q, state_q.aw_idx, sel_live, stat_view, vec_val, running_count_in);
			state_d.bresp = (rd[16] && !state_q.aw_hi) ? tcc_pkg::RESP_OKAY : tcc_pkg::RESP_SLVERR;
			wc = slot(state_q.aw_idx, tcc_pkg::IDX_CTL0);
			wr = slot(state_q.aw_idx, tcc_pkg::IDX_CCR0);
			if (state_q.aw_hi) begin
				do_w = 1'b0;
			end
		end
		if (state_q.bvalid && s_axi_bready_in) begin
			state_d.bvalid = 1'b0;
		end

		// register writes; reserved and read-only bits keep their value
		if (do_w && wc != 4'hF) begin
			bm = bm & tcc_pkg::CTL_WMASK;
			state_d.ctl[wc[2:0]] = (state_q.ctl[wc[2:0]] & ~bm) | (state_q.wdata & bm);
		end
		if (do_w && wr != 4'hF) begin
			state_d.ccr[wr[2:0]] = (state_q.ccr[wr[2:0]] & ~bm) | (state_q.wdata & bm);
		end
		if (do_w && state_q.aw_idx == tcc_pkg::IDX_MASK && state_q.wstrb[0]) begin
			state_d.mask = state_q.wdata[7:0];
		end
		if (do_w && state_q.aw_idx == tcc_pkg::IDX_STAT && state_q.wstrb[0]) begin
			for (int i = 0; i < tcc_pkg::NCH; i++) begin
				if (state_q.wdata[i]) begin
					state_d.ctl[i][tcc_pkg::F_FLAG] = 1'b0;
				end
			end
			if (state_q.wdata[tcc_pkg::STAT_ROLL]) begin
				state_d.roll_flag = 1'b0;
			end
		end

		// read channel; a vector read clears the source it reports
		if (s_axi_arvalid_in && s_axi_arready_out) begin
			do_r = 1'b1;
			rd = read_reg(state_q, s_axi_araddr_in[7:2], sel_live, stat_view, vec_val, running_count_in);
			state_d.rvalid = 1'b1;
			state_d.rdata = {16'h0000, rd[15:0]};
			// a misaligned read answers with an error and no data
			if (s_axi_araddr_in[1:0] != 2'h0) begin
				state_d.rdata = 32'h0000_0000;
			end
			state_d.rresp = (rd[16] && s_axi_araddr_in[1:0] == 2'h0) ? tcc_pkg::RESP_OKAY : tcc_pkg::RESP_SLVERR;
			if (s_axi_araddr_in[1:0] == 2'h0 && s_axi_araddr_in[7:2] == tcc_pkg::IDX_VEC) begin
				if (vec_any) begin
					state_d.ctl[vec_ch][tcc_pkg::F_FLAG] = 1'b0;
				end else if (state_q.roll_flag) begin
					state_d.roll_flag = 1'b0;
				end
			end
		end else if (state_q.rvalid && s_axi_rready_in) begin
			state_d.rvalid = 1'b0;
		end

		// input synchronisers and channel hardware
		// the first flop of each pin pair feeds only the second one
		// hardware sets come after every software clear so that a coincident set wins
		state_d.a_s1 = first_external_input_in;
		state_d.a_s2 = state_q.a_s1;
		state_d.b_s1 = second_external_input_in;
		state_d.b_s2 = state_q.b_s1;
		state_d.sel_q = sel_live;
		state_d.prev = cap_in;
		for (int i = 0; i < tcc_pkg::NCH; i++) begin
			state_d.eq[i] = !state_q.ctl[i][tcc_pkg::F_FUNC] && running_count_in == state_q.ccr[i];
			if (cap_ev[i]) begin
				state_d.ccr[i] = running_count_in;
				if (state_q.ctl[i][tcc_pkg::F_FLAG]) begin
					state_d.ctl[i][tcc_pkg::F_COV] = 1'b1;
				end
			end
			if (cap_ev[i] || match_ev[i]) begin
				state_d.ctl[i][tcc_pkg::F_FLAG] = 1'b1;
			end
			if (match_ev[i]) begin
				state_d.ctl[i][tcc_pkg::F_LATCH] = sel_live[i];
			end
			// waveform: channel action first, period action overrides when coincident
			md = state_q.ctl[i][tcc_pkg::F_MODE_LO +: 3];
			w = state_q.wave[i];
			if (match_ev[i]) begin
				unique case (md)
					tcc_pkg::MODE_SET, tcc_pkg::MODE_SETRST: w = 1'b1;
					tcc_pkg::MODE_RST, tcc_pkg::MODE_RSTSET: w = 1'b0;
					tcc_pkg::MODE_TGRST, tcc_pkg::MODE_TGL, tcc_pkg::MODE_TGSET: w = ~w;
					tcc_pkg::MODE_LEVEL: w = w;
				endcase
			end
			if (match_ev[0]) begin
				unique case (md)
					tcc_pkg::MODE_TGRST, tcc_pkg::MODE_SETRST: w = 1'b0;
					tcc_pkg::MODE_TGSET, tcc_pkg::MODE_RSTSET: w = 1'b1;
					default: w = w;
				endcase
			end
			if (md == tcc_pkg::MODE_LEVEL) begin
				w = state_d.ctl[i][tcc_pkg::F_OUT];
			end
			state_d.wave[i] = w;
		end
		if (rollover_event_in) begin
			state_d.roll_flag = 1'b1;
		end
	end

	// state register with reset and clock enable
	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			state_q <= '0;
		end else if (ce_in) begin
			state_q <= state_d;
		end
	end

	// bus handshakes and outputs
	// readies come from registered state only, so they never wait on a valid
	assign s_axi_awready_out = !state_q.have_aw && !state_q.bvalid;
	assign s_axi_wready_out  = !state_q.have_w && !state_q.bvalid;
	assign s_axi_bvalid_out  = state_q.bvalid;
	assign s_axi_bresp_out   = state_q.bresp;
	assign s_axi_arready_out = !state_q.rvalid;
	assign s_axi_rvalid_out  = state_q.rvalid;
	assign s_axi_rdata_out   = state_q.rdata;
	assign s_axi_rresp_out   = state_q.rresp;
	assign waveform_out      = state_q.wave;
	assign irq_out           = |({state_q.roll_flag, chan_req} & state_q.mask);

endmodule

`default_nettype wire

// >>> test/tcc_pins_model.sv
`timescale 1ns/1ps
`default_nettype none
module tcc_pins_model (
	input  wire logic		clk_in,		// timer clock
	input  wire logic		run_in,		// count when high, load preset when low
	input  wire logic [15:0]	preset_in,	// value loaded while stopped
	input  wire logic [6:0]	a_in,		// wanted first pin levels
	input  wire logic [6:0]	b_in,		// wanted second pin levels
	output logic [15:0]		count_out,	// running count
	output logic			roll_out,	// wrap pulse
	output logic [6:0]		first_out,	// first capture pins
	output logic [6:0]		second_out	// second capture pins
);
	// pins move between clock edges, as a free-running source would
	assign #1 first_out = a_in;
	assign #1 second_out = b_in;

	// counter: held at the preset while stopped, wrap pulse with the step to zero
	always_ff @(posedge clk_in) begin
		roll_out <= 1'b0;
		if (!run_in) begin
			count_out <= preset_in;
		end else begin
			count_out <= count_out + 16'h0001;
			roll_out <= (count_out == 16'hFFFF);
		end
	end
endmodule
`default_nettype wire

// >>> test/tcc_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module tcc_asserts (
	input wire logic		sys_clk_in,		// clock
	input wire logic		sys_rst_in,		// reset
	input wire logic		ce_in,			// clock enable
	input wire logic		s_axi_awvalid_in,	// aw valid
	input wire logic		s_axi_awready_out,	// aw ready
	input wire logic		s_axi_wvalid_in,	// w valid
	input wire logic		s_axi_wready_out,	// w ready
	input wire logic [1:0]	s_axi_bresp_out,	// b resp
	input wire logic		s_axi_bvalid_out,	// b valid
	input wire logic		s_axi_bready_in,	// b ready
	input wire logic		s_axi_arvalid_in,	// ar valid
	input wire logic		s_axi_arready_out,	// ar ready
	input wire logic [31:0]	s_axi_rdata_out,	// r data
	input wire logic		s_axi_rvalid_out,	// r valid
	input wire logic		s_axi_rready_in,	// r ready
	input wire logic [6:0]	waveform_out,		// outputs
	input wire logic		irq_out			// interrupt
);
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (sys_rst_in);

	// bus steps
	sequence s_write_taken;
		s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out && ce_in;
	endsequence
	sequence s_read_taken;
		s_axi_arvalid_in && s_axi_arready_out && ce_in;
	endsequence
	sequence s_read_done;
		s_axi_rvalid_out && s_axi_rready_in && ce_in;
	endsequence

	property p_reset_quiet;
		disable iff (1'b0) sys_rst_in |=> waveform_out == 7'h00 && !irq_out && !s_axi_bvalid_out && !s_axi_rvalid_out;
	endproperty
	property p_ready_after_reset;
		$fell(sys_rst_in) |-> s_axi_awready_out && s_axi_wready_out && s_axi_arready_out;
	endproperty
	property p_write_answer;
		s_write_taken ##1 ce_in |=> s_axi_bvalid_out;
	endproperty
	property p_frozen;
		!ce_in |=> $stable(waveform_out) && $stable(irq_out) && $stable(s_axi_bvalid_out) && $stable(s_axi_rvalid_out);
	endproperty
	property p_read_answer;
		s_read_taken |=> s_axi_rvalid_out;
	endproperty
	property p_resp_stands;
		s_axi_bvalid_out && !(s_axi_bready_in && ce_in) |=> s_axi_bvalid_out && $stable(s_axi_bresp_out);
	endproperty
	property p_rdata_stands;
		s_axi_rvalid_out && !(s_axi_rready_in && ce_in) |=> s_axi_rvalid_out && $stable(s_axi_rdata_out);
	endproperty
	property p_read_release;
		s_read_done |=> !s_axi_rvalid_out && s_axi_arready_out;
	endproperty
	property p_write_refused;
		s_axi_bvalid_out |-> !s_axi_awready_out && !s_axi_wready_out;
	endproperty
	property p_upper_zero;
		s_axi_rvalid_out |-> s_axi_rdata_out[31:16] == 16'h0000;
	endproperty

	a_reset_quiet: assert property (p_reset_quiet) else $error("outputs not cleared by reset");
	a_ready_after_reset: assert property (p_ready_after_reset) else $error("bus not ready after reset");
	a_write_answer: assert property (p_write_answer) else $error("write not answered");
	a_read_answer: assert property (p_read_answer) else $error("read not answered");
	a_resp_stands: assert property (p_resp_stands) else $error("write response dropped");
	a_rdata_stands: assert property (p_rdata_stands) else $error("read data dropped");
	a_read_release: assert property (p_read_release) else $error("read not released");
	a_write_refused: assert property (p_write_refused) else $error("write taken while answering");
	a_upper_zero: assert property (p_upper_zero) else $error("upper read half not zero");
	a_frozen: assert property (p_frozen) else $error("state moved while clock enable low");
endmodule

bind timer_capture_compare_channels tcc_asserts i_tcc_asserts (.sys_clk_in, .sys_rst_in, .ce_in,
	.s_axi_awvalid_in, .s_axi_awready_out, .s_axi_wvalid_in, .s_axi_wready_out, .s_axi_bresp_out,
	.s_axi_bvalid_out, .s_axi_bready_in, .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rdata_out,
	.s_axi_rvalid_out, .s_axi_rready_in, .waveform_out, .irq_out);
`default_nettype wire

// >>> test/timer_capture_compare_channels_tb.sv
`timescale 1ns/1ps
`default_nettype none
module timer_capture_compare_channels_tb;
	logic		sys_clk_in = 1'b0, sys_rst_in = 1'b1, ce_in = 1'b1, run = 1'b0, init;
	logic		s_axi_awvalid_in = 1'b0, s_axi_wvalid_in = 1'b0, s_axi_bready_in = 1'b0;
	logic		s_axi_arvalid_in = 1'b0, s_axi_rready_in = 1'b0, rollover_event_in;
	logic		s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out, s_axi_rvalid_out, irq_out;
	logic [7:0]	s_axi_awaddr_in = 8'h00, s_axi_araddr_in = 8'h00;
	logic [31:0]	s_axi_wdata_in = 32'h0000_0000, s_axi_rdata_out, v;
	logic [3:0]	s_axi_wstrb_in = 4'hF;
	logic [1:0]	s_axi_bresp_out, s_axi_rresp_out;
	logic [6:0]	pin_a = 7'h02, pin_b = 7'h00, first_external_input_in, second_external_input_in, waveform_out;
	logic [15:0]	preset = 16'h1234, running_count_in;
	logic [2:0]	m;
	logic [7:0]	rst_addr [7] = '{8'h08, 8'h38, 8'h48, 8'h78, 8'hB8, 8'hC0, 8'hC8};
	logic [7:0]	vec_exp [5] = '{8'h02, 8'h0A, 8'h0C, 8'h0E, 8'h00};
	int		checks = 0, mismatches = 0, cycles = 0;

	timer_capture_compare_channels i_timer_capture_compare_channels (.sys_clk_in, .sys_rst_in, .ce_in,
		.s_axi_awaddr_in, .s_axi_awvalid_in, .s_axi_awready_out, .s_axi_wdata_in, .s_axi_wstrb_in,
		.s_axi_wvalid_in, .s_axi_wready_out, .s_axi_bresp_out, .s_axi_bvalid_out, .s_axi_bready_in,
		.s_axi_araddr_in, .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rdata_out, .s_axi_rresp_out,
		.s_axi_rvalid_out, .s_axi_rready_in, .first_external_input_in, .second_external_input_in,
		.running_count_in, .rollover_event_in, .waveform_out, .irq_out);
	tcc_pins_model i_tcc_pins_model (.clk_in(sys_clk_in), .run_in(run), .preset_in(preset), .a_in(pin_a),
		.b_in(pin_b), .count_out(running_count_in), .roll_out(rollover_event_in),
		.first_out(first_external_input_in), .second_out(second_external_input_in));

	// 250 mhz clock
	initial begin
		forever #2 sys_clk_in = ~sys_clk_in;
	end

	// hang guard
	always @(posedge sys_clk_in) begin
		cycles <= cycles + 1;
		if (cycles == 6000) begin
			mismatches++;
			finish_test();
		end
	end

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask

	// bus write: address and data offered together, each released when taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk_in);
		s_axi_awaddr_in <= a;
		s_axi_wdata_in <= d;
		s_axi_awvalid_in <= 1'b1;
		s_axi_wvalid_in <= 1'b1;
		s_axi_bready_in <= 1'b1;
		do begin
			@(posedge sys_clk_in);
			if (s_axi_awready_out) s_axi_awvalid_in <= 1'b0;
			if (s_axi_wready_out) s_axi_wvalid_in <= 1'b0;
		end while (!s_axi_bvalid_out);
		s_axi_bready_in <= 1'b0;
		chk("bresp", 32'h0000_0000, {30'h0, s_axi_bresp_out});
	endtask

	// bus read with masked compare of data and response
	task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [31:0] k = 32'hFFFF_FFFF,
		input logic [1:0] r = tcc_pkg::RESP_OKAY);
		@(posedge sys_clk_in);
		s_axi_araddr_in <= a;
		s_axi_arvalid_in <= 1'b1;
		s_axi_rready_in <= 1'b1;
		do begin
			@(posedge sys_clk_in);
			if (s_axi_arready_out) s_axi_arvalid_in <= 1'b0;
		end while (!s_axi_rvalid_out);
		s_axi_rready_in <= 1'b0;
		chk($sformatf("rresp %h", a), {30'h0, r}, {30'h0, s_axi_rresp_out});
		chk($sformatf("rdata %h", a), e, s_axi_rdata_out & k);
	endtask

	task automatic finish_test();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// channel zero stays in mode 0 for the whole run
	initial begin
		repeat (8) @(posedge sys_clk_in);
		sys_rst_in <= 1'b0;
		foreach (rst_addr[i]) rdc(rst_addr[i], 32'h0000_0000);
		rdc(8'hFC, 32'h0000_0000, 32'hFFFF_FFFF, tcc_pkg::RESP_SLVERR);
		rdc(8'h0A, 32'h0000_0000, 32'hFFFF_FFFF, tcc_pkg::RESP_SLVERR);
		$display("reset and map test done");
		for (int s = 0; s < 4; s++) begin
			wr(8'h10, 32'(s) << 12);
			repeat (6) @(posedge sys_clk_in);
			rdc(8'h10, (s == 0 || s == 3) ? 32'h0000_0008 : 32'h0000_0000, 32'h0000_0008);
		end
		$display("source test done");
		wr(8'h18, 32'h0000_4100);
		pin_a[2] <= 1'b1;
		repeat (8) @(posedge sys_clk_in);
		rdc(8'h58, 32'h0000_1234);
		rdc(8'h40, 32'h0000_1234);
		preset <= 16'h5678;
		pin_a[2] <= 1'b0;
		repeat (8) @(posedge sys_clk_in);
		pin_a[2] <= 1'b1;
		repeat (8) @(posedge sys_clk_in);
		rdc(8'h58, 32'h0000_5678);
		rdc(8'h18, 32'h0000_0003, 32'h0000_0003);
		rdc(8'hB8, 32'h0000_0004);
		rdc(8'hB8, 32'h0000_0000);
		rdc(8'h18, 32'h0000_0002, 32'h0000_0003);
		wr(8'h18, 32'h0000_0000);
		$display("capture test done");
		for (int e = 0; e < 4; e++) begin
			v = 32'(e) << 14 | 32'(e == 3) << 11 | 32'h0000_0100;
			wr(8'h20, v);
			pin_a[3] <= 1'b1;
			repeat (8) @(posedge sys_clk_in);
			rdc(8'h20, 32'(e & 1), 32'h0000_0001);
			wr(8'h20, v);
			pin_a[3] <= 1'b0;
			repeat (8) @(posedge sys_clk_in);
			rdc(8'h20, 32'(e >> 1), 32'h0000_0001);
		end
		wr(8'h20, 32'h0000_0000);
		$display("edge test done");
		wr(8'h68, 32'h0000_0010);
		for (int i = 0; i < 14; i++) begin
			m = 3'(i % 7 + 1);
			init = (i >= 7);
			wr(8'h28, 32'h0000_3000 | 32'(init) << 2);
			preset <= 16'h000F;
			repeat (4) @(posedge sys_clk_in);
			chk("wave level", 32'(init), 32'(waveform_out[4]));
			wr(8'h28, 32'h0000_3000 | 32'(m) << 5 | 32'(init) << 2);
			ce_in <= 1'b0;
			preset <= 16'h0010;
			repeat (4) @(posedge sys_clk_in);
			chk("wave frozen", 32'(init), 32'(waveform_out[4]));
			ce_in <= 1'b1;
			repeat (4) @(posedge sys_clk_in);
			v = (m == 1 || m == 3) ? 32'h1 : (m == 5 || m == 7) ? 32'h0 : 32'(!init);
			chk("wave mode", v, 32'(waveform_out[4]));
		end
		rdc(8'h28, 32'h0000_0401, 32'h0000_0401);
		$display("compare test done");
		wr(8'hC0, 32'h0000_00FF);
		wr(8'hC8, 32'h0000_0010);
		chk("irq", 32'h0, 32'(irq_out));
		wr(8'h28, 32'h0000_3011);
		chk("irq", 32'h1, 32'(irq_out));
		wr(8'hC8, 32'h0000_0000);
		chk("irq", 32'h0, 32'(irq_out));
		wr(8'hC8, 32'h0000_0010);
		chk("irq", 32'h1, 32'(irq_out));
		wr(8'hC0, 32'h0000_0010);
		chk("irq", 32'h0, 32'(irq_out));
		wr(8'h28, 32'h0000_3011);
		rdc(8'hB8, 32'h0000_0008);
		chk("irq", 32'h0, 32'(irq_out));
		$display("interrupt test done");
		preset <= 16'hFFFE;
		@(posedge sys_clk_in);
		run <= 1'b1;
		repeat (4) @(posedge sys_clk_in);
		run <= 1'b0;
		preset <= 16'h1234;
		repeat (6) @(posedge sys_clk_in);
		foreach (vec_exp[i]) rdc(8'hB8, {24'h0, vec_exp[i]});
		$display("vector test done");
		finish_test();
	end
endmodule
`default_nettype wire
